// ---- rtl/qsb_bank.sv ----
`timescale 1ns/1ns
`default_nettype none

module qsb_bank (
    input  wire logic               ref_clk_i,
    input  wire logic               sys_rst_i,
    input  wire qsb_pkg::qsb_meas_t meas_i,
    input  wire qsb_pkg::qsb_cond_t cond_i,
    output logic [15:0]             summary_o,
    input  wire logic [7:0]         s_axi_awaddr_i,
    input  wire logic               s_axi_awvalid_i,
    output logic                    s_axi_awready_o,
    input  wire logic [31:0]        s_axi_wdata_i,
    input  wire logic [3:0]         s_axi_wstrb_i,
    input  wire logic               s_axi_wvalid_i,
    output logic                    s_axi_wready_o,
    output logic [1:0]              s_axi_bresp_o,
    output logic                    s_axi_bvalid_o,
    input  wire logic               s_axi_bready_i,
    input  wire logic [7:0]         s_axi_araddr_i,
    input  wire logic               s_axi_arvalid_i,
    output logic                    s_axi_arready_o,
    output logic [31:0]             s_axi_rdata_o,
    output logic [1:0]              s_axi_rresp_o,
    output logic                    s_axi_rvalid_o,
    input  wire logic               s_axi_rready_i
);
    import qsb_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    qsb_meas_t   meas_s1;
    qsb_meas_t   meas;
    qsb_cond_t   cond_s1;
    qsb_cond_t   cond;

    // Two flip-flops per pin; a word caught mid-change can mis-compare one cycle
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            meas_s1 <= '0;
            meas    <= '0;
            cond_s1 <= '0;
            cond    <= '0;
        end else begin
            meas_s1 <= meas_i;
            meas    <= meas_s1;
            cond_s1 <= cond_i;
            cond    <= cond_s1;
        end
    end

    // ------------------------------------------------------------
    // Trip limits and control
    // ------------------------------------------------------------
    logic [15:0] ov_limit;
    logic [15:0] uv_limit;
    logic [15:0] oc_limit;
    logic [15:0] uc_limit;
    logic [15:0] op_limit;
    logic [15:0] up_limit;
    logic [15:0] temp_max;
    logic        ov_user_en;

    logic [1:0]  voltage_limit_flags;
    logic [1:0]  current_limit_flags;
    logic [1:0]  power_limit_flags;
    logic [1:0]  thermal_limit_flags;
    logic [15:0] questionable_condition_summary;
    logic        regulation_summary;
    logic [22:0] temp_scaled;
    logic [22:0] temp_warn;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic [7:0]  aw_addr;
    logic        aw_held;
    logic [31:0] w_data;
    logic        w_held;
    logic        wr_go;
    logic        wr_hit;

    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
    assign wr_go           = aw_held && w_held && !s_axi_bvalid_o;

    // Address and data are taken in either order
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // Byte lanes 0 and 1 hold the 16-bit fields
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
        logic [15:0] res;
        res = old_v;
        if (strb[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (strb[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction : merge16

    logic [3:0] w_strb;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            w_strb <= 4'h0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_strb <= s_axi_wstrb_i;
        end
    end

    // Address decode for writable registers
    always_comb begin
        if (aw_addr == QSB_OV_LIM_OFS) begin
            wr_hit = 1'b1;
        end else if (aw_addr == QSB_UV_LIM_OFS) begin
            wr_hit = 1'b1;
        end else if (aw_addr == QSB_OC_LIM_OFS) begin
            wr_hit = 1'b1;
        end else if (aw_addr == QSB_UC_LIM_OFS) begin
            wr_hit = 1'b1;
        end else if (aw_addr == QSB_OP_LIM_OFS) begin
            wr_hit = 1'b1;
        end else if (aw_addr == QSB_UP_LIM_OFS) begin
            wr_hit = 1'b1;
        end else if (aw_addr == QSB_TMAX_OFS) begin
            wr_hit = 1'b1;
        end else if (aw_addr == QSB_CTRL_OFS) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // Limit and control registers
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ov_limit   <= QSB_LIM_RST;
            uv_limit   <= QSB_LIM_RST;
            oc_limit   <= QSB_LIM_RST;
            uc_limit   <= QSB_LIM_RST;
            op_limit   <= QSB_LIM_RST;
            up_limit   <= QSB_LIM_RST;
            temp_max   <= QSB_TMAX_RST;
            ov_user_en <= 1'b0;
        end else if (wr_go) begin
            if (aw_addr == QSB_OV_LIM_OFS) begin
                ov_limit <= merge16(ov_limit, w_data, w_strb);
            end else if (aw_addr == QSB_UV_LIM_OFS) begin
                uv_limit <= merge16(uv_limit, w_data, w_strb);
            end else if (aw_addr == QSB_OC_LIM_OFS) begin
                oc_limit <= merge16(oc_limit, w_data, w_strb);
            end else if (aw_addr == QSB_UC_LIM_OFS) begin
                uc_limit <= merge16(uc_limit, w_data, w_strb);
            end else if (aw_addr == QSB_OP_LIM_OFS) begin
                op_limit <= merge16(op_limit, w_data, w_strb);
            end else if (aw_addr == QSB_UP_LIM_OFS) begin
                up_limit <= merge16(up_limit, w_data, w_strb);
            end else if (aw_addr == QSB_TMAX_OFS) begin
                temp_max <= merge16(temp_max, w_data, w_strb);
            end else if (aw_addr == QSB_CTRL_OFS && w_strb[0]) begin
                ov_user_en <= w_data[0];
            end
        end
    end

    // Write response, SLVERR on unmapped or read-only address
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= QSB_RESP_OK;
        end else if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? QSB_RESP_OK : QSB_RESP_ERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Condition detection
    // ------------------------------------------------------------
    // Ninety percent compare without division: 100*T > 90*Tmax
    assign temp_scaled = 23'(meas.temperature) * 23'(100);
    assign temp_warn   = 23'(temp_max) * 23'(QSB_WARN_PCT);

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            voltage_limit_flags <= 2'h0;
            current_limit_flags <= 2'h0;
            power_limit_flags   <= 2'h0;
            thermal_limit_flags <= 2'h0;
        end else begin
            voltage_limit_flags[QSB_BIT_OVER] <= cond.fixed_ov_trip ||
                (ov_user_en && meas.voltage > ov_limit);
            voltage_limit_flags[QSB_BIT_UNDER] <= cond.operating &&
                meas.voltage < uv_limit;
            current_limit_flags[QSB_BIT_OVER] <= cond.operating &&
                meas.current > oc_limit;
            current_limit_flags[QSB_BIT_UNDER] <= cond.operating &&
                meas.current < uc_limit;
            power_limit_flags[QSB_BIT_OVER] <= cond.operating &&
                meas.power > op_limit;
            power_limit_flags[QSB_BIT_UNDER] <= cond.operating &&
                meas.power < up_limit;
            thermal_limit_flags[QSB_BIT_TOVER] <= meas.temperature > temp_max;
            thermal_limit_flags[QSB_BIT_THIGH] <= temp_scaled > temp_warn;
        end
    end

    // Regulation summary from the three mode indicators
    assign regulation_summary = cond.regulating[QSB_REG_VOLT] ||
                                cond.regulating[QSB_REG_CURR] ||
                                cond.regulating[QSB_REG_POWER];

    // Summary register, unused bits held at zero
    always_comb begin
        questionable_condition_summary                = 16'h0000;
        questionable_condition_summary[QSB_BIT_VOLT]  = |voltage_limit_flags;
        questionable_condition_summary[QSB_BIT_CURR]  = |current_limit_flags;
        questionable_condition_summary[QSB_BIT_POWER] = |power_limit_flags;
        questionable_condition_summary[QSB_BIT_THERM] = |thermal_limit_flags;
        questionable_condition_summary[QSB_BIT_CAL]   = cond.cal_error;
        questionable_condition_summary[QSB_BIT_MAINS] = cond.mains_input_failure;
        questionable_condition_summary[QSB_BIT_UNREG] = !regulation_summary;
    end

    // Summary held in a flop so the pin carries registered data
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            summary_o <= QSB_SUMMARY_RST;
        end else begin
            summary_o <= questionable_condition_summary;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready_o = !s_axi_rvalid_o;

    // Read mux over the summary, four sub-registers and limits
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= QSB_RESP_OK;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o  <= QSB_RESP_OK;
            if (s_axi_araddr_i == QSB_SUMMARY_OFS) begin
                s_axi_rdata_o <= {16'h0000, questionable_condition_summary};
            end else if (s_axi_araddr_i == QSB_VOLT_OFS) begin
                s_axi_rdata_o <= {30'h0, voltage_limit_flags};
            end else if (s_axi_araddr_i == QSB_CURR_OFS) begin
                s_axi_rdata_o <= {30'h0, current_limit_flags};
            end else if (s_axi_araddr_i == QSB_POWER_OFS) begin
                s_axi_rdata_o <= {30'h0, power_limit_flags};
            end else if (s_axi_araddr_i == QSB_THERM_OFS) begin
                s_axi_rdata_o <= {30'h0, thermal_limit_flags};
            end else if (s_axi_araddr_i == QSB_OV_LIM_OFS) begin
                s_axi_rdata_o <= {16'h0000, ov_limit};
            end else if (s_axi_araddr_i == QSB_UV_LIM_OFS) begin
                s_axi_rdata_o <= {16'h0000, uv_limit};
            end else if (s_axi_araddr_i == QSB_OC_LIM_OFS) begin
                s_axi_rdata_o <= {16'h0000, oc_limit};
            end else if (s_axi_araddr_i == QSB_UC_LIM_OFS) begin
                s_axi_rdata_o <= {16'h0000, uc_limit};
            end else if (s_axi_araddr_i == QSB_OP_LIM_OFS) begin
                s_axi_rdata_o <= {16'h0000, op_limit};
            end else if (s_axi_araddr_i == QSB_UP_LIM_OFS) begin
                s_axi_rdata_o <= {16'h0000, up_limit};
            end else if (s_axi_araddr_i == QSB_TMAX_OFS) begin
                s_axi_rdata_o <= {16'h0000, temp_max};
            end else if (s_axi_araddr_i == QSB_CTRL_OFS) begin
                s_axi_rdata_o <= {31'h0, ov_user_en};
            end else begin
                s_axi_rdata_o <= 32'h0000_0000;
                s_axi_rresp_o <= QSB_RESP_ERR;
            end
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence meas_ready_s;
        !sys_rst_i [*3];
    endsequence

    unused_bits_zero_a: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (summary_o & 16'hE6E4) == 16'h0000)
        else $error("unused summary bit set");

    volt_summary_a: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        summary_o[0] == ($past(voltage_limit_flags) != 2'h0))
        else $error("voltage summary mismatch");

    curr_summary_a: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        summary_o[1] == ($past(current_limit_flags) != 2'h0))
        else $error("current summary mismatch");

    power_therm_sum_a: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        summary_o[3] == ($past(power_limit_flags) != 2'h0) &&
        summary_o[4] == ($past(thermal_limit_flags) != 2'h0))
        else $error("power or thermal summary mismatch");

    unreg_flag_a: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        summary_o[12] == ($past(cond.regulating) == 3'h0))
        else $error("unregulated flag mismatch");

    cal_mains_pass_a: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        summary_o[8] == $past(cond.cal_error) && summary_o[11] == $past(cond.mains_input_failure))
        else $error("calibration or mains flag mismatch");

    under_volt_gate_a: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        meas_ready_s ##0 !$past(cond.operating) |-> !voltage_limit_flags[1])
        else $error("under-voltage set while not operating");

    over_curr_set_a: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        meas_ready_s ##0 (cond.operating && meas.current > oc_limit) |=> current_limit_flags[0])
        else $error("over-current not flagged");

    over_power_gate_a: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        meas_ready_s ##0 (!cond.operating) |=> !power_limit_flags[0] && !power_limit_flags[1])
        else $error("power flag set while not operating");

    over_temp_set_a: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        meas_ready_s ##0 (meas.temperature > temp_max) |=>
        thermal_limit_flags[0] && thermal_limit_flags[1])
        else $error("over-temperature not flagged");

    fixed_ov_a: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        meas_ready_s ##0 cond.fixed_ov_trip |=> voltage_limit_flags[0])
        else $error("fixed over-voltage not flagged");

endmodule : qsb_bank

`default_nettype wire

// ---- rtl/qsb_pkg.sv ----
`default_nettype none

package qsb_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] QSB_SUMMARY_OFS  = 8'h00;
    localparam logic [7:0] QSB_VOLT_OFS     = 8'h04;
    localparam logic [7:0] QSB_CURR_OFS     = 8'h08;
    localparam logic [7:0] QSB_POWER_OFS    = 8'h0C;
    localparam logic [7:0] QSB_THERM_OFS    = 8'h10;
    localparam logic [7:0] QSB_OV_LIM_OFS   = 8'h14;
    localparam logic [7:0] QSB_UV_LIM_OFS   = 8'h18;
    localparam logic [7:0] QSB_OC_LIM_OFS   = 8'h1C;
    localparam logic [7:0] QSB_UC_LIM_OFS   = 8'h20;
    localparam logic [7:0] QSB_OP_LIM_OFS   = 8'h24;
    localparam logic [7:0] QSB_UP_LIM_OFS   = 8'h28;
    localparam logic [7:0] QSB_TMAX_OFS     = 8'h2C;
    localparam logic [7:0] QSB_CTRL_OFS     = 8'h30;

    // ------------------------------------------------------------
    // Summary register bit positions
    // ------------------------------------------------------------
    localparam int QSB_BIT_VOLT  = 0;
    localparam int QSB_BIT_CURR  = 1;
    localparam int QSB_BIT_POWER = 3;
    localparam int QSB_BIT_THERM = 4;
    localparam int QSB_BIT_CAL   = 8;
    localparam int QSB_BIT_MAINS = 11;
    localparam int QSB_BIT_UNREG = 12;

    // Sub-register bit positions
    localparam int QSB_BIT_OVER  = 0;
    localparam int QSB_BIT_UNDER = 1;
    localparam int QSB_BIT_TOVER = 0;
    localparam int QSB_BIT_THIGH = 1;

    // Regulation indicator positions
    localparam int QSB_REG_VOLT  = 0;
    localparam int QSB_REG_CURR  = 1;
    localparam int QSB_REG_POWER = 2;

    // Early warning fraction of maximum temperature, in percent
    localparam int QSB_WARN_PCT = 90;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] QSB_LIM_RST  = 16'h0000;
    localparam logic [15:0] QSB_TMAX_RST = 16'hFFFF;
    localparam logic [15:0] QSB_SUMMARY_RST = 16'h1000; // No regulation mode: unregulated set
    localparam logic [1:0]  QSB_RESP_OK  = 2'h0;
    localparam logic [1:0]  QSB_RESP_ERR = 2'h2;

    // ------------------------------------------------------------
    // Measurement carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] voltage;
        logic [15:0] current;
        logic [15:0] power;
        logic [15:0] temperature;
    } qsb_meas_t;

    // Unit condition carrier
    typedef struct packed {
        logic       operating;
        logic       fixed_ov_trip;
        logic       cal_error;
        logic       mains_input_failure;
        logic [2:0] regulating;
    } qsb_cond_t;

endpackage : qsb_pkg

`default_nettype wire

// ---- test/test_questionable_status_bank.sv ----
`timescale 1ns/1ns
`default_nettype none

module test_questionable_status_bank;
    import qsb_pkg::*;

    // ------------------------------------------------------------
    // Bench signals, all inputs valued at time zero
    // ------------------------------------------------------------
    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    qsb_meas_t   meas      = '0;
    qsb_cond_t   cond      = '0;
    logic [15:0] summary;
    logic [7:0]  awaddr    = '0;
    logic [7:0]  araddr    = '0;
    logic [31:0] wdata     = '0;
    logic [3:0]  wstrb     = 4'hF;
    logic [31:0] rdata;
    logic        awvalid   = 1'b0;
    logic        wvalid    = 1'b0;
    logic        bready    = 1'b0;
    logic        arvalid   = 1'b0;
    logic        rready    = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    int          error_cnt = 0;
    int          checks_done = 0;

    // Clock at 25 MHz
    always #20 ref_clk_i = ~ref_clk_i;

    qsb_bank dut_u (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .meas_i(meas), .cond_i(cond),
        .summary_o(summary), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready)
    );

    // ------------------------------------------------------------
    // Shared tasks: compare, bus cycles, settling
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // Write; address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge ref_clk_i);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", exp, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge ref_clk_i);
    endtask : axi_rd

    // Two sync stages, a flag stage and the summary stage, plus margin
    task automatic settle;
        repeat (6) @(posedge ref_clk_i);
    endtask : settle

    // Summary seen at the pin and over the bus
    task automatic sum_chk(input logic [15:0] exp);
        chk("summary_o", {16'h0, exp}, {16'h0, summary});
        axi_rd(QSB_SUMMARY_OFS, {16'h0, exp}, QSB_RESP_OK);
    endtask : sum_chk

    task automatic cond_case(input logic [6:0] c, input logic [15:0] exp);
        cond <= qsb_cond_t'(c);
        settle();
        sum_chk(exp);
    endtask : cond_case

    task automatic meas_case(input int sel, input logic [15:0] v, input logic op,
                             input logic [7:0] fo, input int b, input logic [1:0] ef);
        case (sel)
            0: meas.voltage <= v;
            1: meas.current <= v;
            2: meas.power <= v;
            default: meas.temperature <= v;
        endcase
        cond.operating <= op;
        settle();
        sum_chk((ef != 2'b00) ? (16'h1 << b) : 16'h0);
        axi_rd(fo, {30'h0, ef}, QSB_RESP_OK);
    endtask : meas_case

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        settle();
        sum_chk(16'h1000);
        axi_rd(QSB_TMAX_OFS, 32'h0000FFFF, QSB_RESP_OK);
        axi_rd(QSB_OV_LIM_OFS, 32'h0, QSB_RESP_OK);
        wstrb <= 4'h2;
        axi_wr(QSB_OV_LIM_OFS, 32'h0000_1234, QSB_RESP_OK);
        wstrb <= 4'hF;
        axi_rd(QSB_OV_LIM_OFS, 32'h0000_1200, QSB_RESP_OK);
        axi_wr(QSB_VOLT_OFS, 32'h3, QSB_RESP_ERR);
        axi_rd(QSB_VOLT_OFS, 32'h0, QSB_RESP_OK);
        axi_rd(8'h40, 32'h0, QSB_RESP_ERR);
        $display("test reset done");
    endtask : t_reset

    task automatic t_cond;
        cond_case(7'h01, 16'h0000);
        cond_case(7'h02, 16'h0000);
        cond_case(7'h04, 16'h0000);
        cond_case(7'h11, 16'h0100);
        cond_case(7'h09, 16'h0800);
        cond_case(7'h18, 16'h1900);
        cond_case(7'h01, 16'h0000);
        $display("test conditions done");
    endtask : t_cond

    // Over limit 800, under limit 200, limits strict
    task automatic t_limits(input int sel, input logic [7:0] hi, input logic [7:0] lo,
                            input logic [7:0] fo, input int b);
        axi_wr(hi, 32'h0000_0320, QSB_RESP_OK);
        axi_wr(lo, 32'h0000_00C8, QSB_RESP_OK);
        meas_case(sel, 16'h0321, 1'b1, fo, b, 2'h1);
        meas_case(sel, 16'h0320, 1'b1, fo, b, 2'h0);
        meas_case(sel, 16'h00C7, 1'b1, fo, b, 2'h2);
        meas_case(sel, 16'h00C7, 1'b0, fo, b, 2'h0);
        meas_case(sel, 16'h0321, 1'b0, fo, b, (sel == 0) ? 2'h1 : 2'h0);
        meas_case(sel, 16'h00C8, 1'b1, fo, b, 2'h0);
        axi_wr(lo, 32'h0, QSB_RESP_OK);
        meas_case(sel, 16'h0, 1'b1, fo, b, 2'b00);
        $display("test limits %0d done", sel);
    endtask : t_limits

    task automatic t_fixed_ov;
        axi_wr(QSB_CTRL_OFS, 32'h0, QSB_RESP_OK);
        cond.fixed_ov_trip <= 1'b1;
        meas_case(0, 16'h000A, 1'b0, QSB_VOLT_OFS, QSB_BIT_VOLT, 2'h1);
        cond.fixed_ov_trip <= 1'b0;
        meas_case(0, 16'h0000, 1'b1, QSB_VOLT_OFS, QSB_BIT_VOLT, 2'h0);
        $display("test fixed trip done");
    endtask : t_fixed_ov

    // Maximum 1000, warning above 900
    task automatic t_temp;
        axi_wr(QSB_TMAX_OFS, 32'h0000_03E8, QSB_RESP_OK);
        meas_case(3, 16'h0384, 1'b1, QSB_THERM_OFS, QSB_BIT_THERM, 2'h0);
        meas_case(3, 16'h0385, 1'b0, QSB_THERM_OFS, QSB_BIT_THERM, 2'h2);
        meas_case(3, 16'h03E8, 1'b1, QSB_THERM_OFS, QSB_BIT_THERM, 2'h2);
        meas_case(3, 16'h03E9, 1'b1, QSB_THERM_OFS, QSB_BIT_THERM, 2'h3);
        meas_case(3, 16'h0000, 1'b1, QSB_THERM_OFS, QSB_BIT_THERM, 2'h0);
        $display("test temperature done");
    endtask : t_temp

    // ------------------------------------------------------------
    // Closing, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic final_report;
        $display("Checks made %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // Run needs about 500 cycles; cut a hang well beyond that
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        error_cnt++;
        final_report();
    end

    initial begin
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_cond();
        axi_wr(QSB_CTRL_OFS, 32'h1, QSB_RESP_OK);
        axi_rd(QSB_CTRL_OFS, 32'h1, QSB_RESP_OK);
        t_limits(0, QSB_OV_LIM_OFS, QSB_UV_LIM_OFS, QSB_VOLT_OFS, QSB_BIT_VOLT);
        t_limits(1, QSB_OC_LIM_OFS, QSB_UC_LIM_OFS, QSB_CURR_OFS, QSB_BIT_CURR);
        t_limits(2, QSB_OP_LIM_OFS, QSB_UP_LIM_OFS, QSB_POWER_OFS, QSB_BIT_POWER);
        t_fixed_ov();
        t_temp();
        final_report();
    end

endmodule : test_questionable_status_bank

`default_nettype wire
